/* logic/cs_status_regs.sv */
/*
 Charger status register bank. Holds the control register with the
 thermistor beta and die threshold selects, and the two read-only
 charger status registers whose flags derive from condition codes.
 Assumes condition inputs arrive asynchronously from the analog side
 and that the host reaches registers through the device's serial
 slave, which presents a single-cycle read or write strobe here.
*/
`timescale 1ns/1ps
`default_nettype none

module cs_status_regs
   import cs_pkg::*;
(
   // Clock, reset, enable
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // Host register port
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Analog condition levels
   input wire logic battery_attach,
   input wire logic [2:0] battery_condition_code,
   input wire logic [1:0] input_supply_state,
   input wire logic [2:0] battery_temp_zone,
   input wire logic [1:0] safety_timer_state,
   input wire logic input_current_limit_hit,
   input wire logic [7:0] die_temp_c,
   // Decoded settings and flags
   output logic [12:0] thermistor_beta_value,
   output logic [7:0] die_heat_threshold_c,
   output logic charger_running_flag,
   output logic thermal_foldback_flag,
   output logic input_power_good,
   output logic status_readable
);

   cs_cond_t cond_raw;
   cs_cond_t cond;
   cs_req_t req;
   cs_flags_t flags;
   logic [7:0] ctrl7_ff;
   logic [7:0] nxt_ctrl7;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic rvalid_ff;
   logic [12:0] beta_ff;
   logic [7:0] thresh_ff;
   logic run_ff;
   logic fold_ff;
   logic pwr_ff;
   logic readable_ff;
   logic [2:0] beta_sel;
   logic [2:0] thm_sel;
   logic [12:0] beta_dec;
   logic [7:0] thresh_dec;
   logic [7:0] summary_word;
   logic [7:0] input_word;
   logic temp_suspend;
   logic timer_suspend;

   // Gather the asynchronous conditions
   always_comb
   begin
      cond_raw.battery_attach = battery_attach;
      cond_raw.battery_condition_code = battery_condition_code;
      cond_raw.input_supply_state = input_supply_state;
      cond_raw.battery_temp_zone = battery_temp_zone;
      cond_raw.safety_timer_state = safety_timer_state;
      cond_raw.input_current_limit_hit = input_current_limit_hit;
      cond_raw.die_temp_c = die_temp_c;
   end

   // Bring conditions into the clock domain
   cs_sync #(
      .WIDTH($bits(cs_cond_t)),
      .RST_VAL(CS_COND_RST)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .d(cond_raw),
      .q(cond)
   );

   // Host request bundle
   always_comb
   begin
      req.rd = reg_rd;
      req.wr = reg_wr;
      req.addr = reg_addr;
      req.wdata = reg_wdata;
   end

   // Select fields of the control register
   assign beta_sel = ctrl7_ff[CS_BETA_LSB +: 3];
   assign thm_sel = ctrl7_ff[CS_THM_LSB +: 3];

   cs_decode u_decode (
      .thermistor_beta_sel(beta_sel),
      .die_heat_threshold_sel(thm_sel),
      .beta_value_k(beta_dec),
      .threshold_c(thresh_dec)
   );

   // Suspend conditions for the charger
   always_comb
   begin
      temp_suspend = 1'b0;
      case (cond.battery_temp_zone)
         CS_TZ_COLD: temp_suspend = 1'b1;
         CS_TZ_HOT: temp_suspend = 1'b1;
         CS_TZ_NOMINAL, CS_TZ_COOL, CS_TZ_WARM: temp_suspend = 1'b0;
         default: temp_suspend = 1'b0;
      endcase
   end

   // Any non-zero timer state suspends
   assign timer_suspend = (cond.safety_timer_state != CS_TMR_NO_EFFECT);

   // Summary flags straight from the codes
   always_comb
   begin
      flags.battery_attach_flag = cond.battery_attach;
      flags.battery_valid = 1'b1;
      case (cond.battery_condition_code)
         CS_BAT_MISSING: flags.battery_valid = 1'b0;
         CS_BAT_IN_RESET: flags.battery_valid = 1'b0;
         default: flags.battery_valid = 1'b1;
      endcase
      flags.input_power_good =
         (cond.input_supply_state == CS_SUP_VALID);
      flags.charger_running_flag = !(temp_suspend || timer_suspend);
      flags.thermal_foldback_flag = (cond.die_temp_c > thresh_dec);
   end

   // Register images, reserved bits at zero
   always_comb
   begin
      summary_word = 8'h00;
      summary_word[CS_ATTACH_BIT] = flags.battery_attach_flag;
      summary_word[CS_BATOK_BIT] = flags.battery_valid;
      summary_word[CS_PWROK_BIT] = flags.input_power_good;
      summary_word[CS_RUN_BIT] = flags.charger_running_flag;
   end

   always_comb
   begin
      input_word = 8'h00;
      input_word[CS_SUPPLY_LSB +: 2] = cond.input_supply_state;
      input_word[CS_FOLD_BIT] = flags.thermal_foldback_flag;
   end

   // Control register write; status offsets take no write
   always_comb
   begin
      nxt_ctrl7 = ctrl7_ff;
      if (req.wr && req.addr == CS_OFS_CHG_CTRL7)
      begin
         nxt_ctrl7 = req.wdata & CS_CTRL7_MASK;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl7_ff <= CS_CTRL7_RST;
      end
      else if (ce)
      begin
         ctrl7_ff <= nxt_ctrl7;
      end
   end

   // Read mux, built in the request cycle
   always_comb
   begin
      case (req.addr)
         CS_OFS_CHG_CTRL7: nxt_rdata = ctrl7_ff;
         CS_OFS_SUMMARY: nxt_rdata = summary_word;
         CS_OFS_INPUT: nxt_rdata = input_word;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end
      else if (ce)
      begin
         rvalid_ff <= req.rd;
         if (req.rd)
         begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // Decoded settings held for the analog side
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         beta_ff <= 13'he1a;
         thresh_ff <= 8'h64;
      end
      else if (ce)
      begin
         beta_ff <= beta_dec;
         thresh_ff <= thresh_dec;
      end
   end

   // Flag outputs, reset to the register defaults
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         run_ff <= 1'b1;
         fold_ff <= 1'b0;
         pwr_ff <= 1'b0;
         readable_ff <= 1'b1;
      end
      else if (ce)
      begin
         run_ff <= flags.charger_running_flag;
         fold_ff <= flags.thermal_foldback_flag;
         pwr_ff <= flags.input_power_good;
         readable_ff <= !cond.input_current_limit_hit;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign thermistor_beta_value = beta_ff;
   assign die_heat_threshold_c = thresh_ff;
   assign charger_running_flag = run_ff;
   assign thermal_foldback_flag = fold_ff;
   assign input_power_good = pwr_ff;
   assign status_readable = readable_ff;

endmodule

`default_nettype wire

/* logic/cs_pkg.sv */
/*
 Package for the charger status register bank: register offsets, field
 positions, reset values, condition codes and the carrier struct.
 Assumes a single clock domain and an 8-bit register port.
*/
`default_nettype none

package cs_pkg;

   // Register offsets
   localparam logic [7:0] CS_OFS_CHG_CTRL7 = 8'h17;
   localparam logic [7:0] CS_OFS_SUMMARY = 8'h18;
   localparam logic [7:0] CS_OFS_INPUT = 8'h19;

   // Control register fields and reset values
   localparam int CS_BETA_LSB = 5;
   localparam int CS_THM_LSB = 0;
   localparam logic [2:0] CS_BETA_RST = 3'h1;
   localparam logic [2:0] CS_THM_RST = 3'h4;
   localparam logic [7:0] CS_CTRL7_RST = 8'h24;
   localparam logic [7:0] CS_CTRL7_MASK = 8'he7;

   // Summary status bit positions
   localparam int CS_ATTACH_BIT = 7;
   localparam int CS_BATOK_BIT = 6;
   localparam int CS_PWROK_BIT = 5;
   localparam int CS_RUN_BIT = 4;

   // Input status bit positions
   localparam int CS_SUPPLY_LSB = 6;
   localparam int CS_FOLD_BIT = 4;

   // Battery condition codes
   localparam logic [2:0] CS_BAT_MISSING = 3'h0;
   localparam logic [2:0] CS_BAT_DETECT = 3'h1;
   localparam logic [2:0] CS_BAT_RSVD = 3'h6;
   localparam logic [2:0] CS_BAT_IN_RESET = 3'h7;

   // Input supply states
   localparam logic [1:0] CS_SUP_UNDERVOLT = 2'h0;
   localparam logic [1:0] CS_SUP_HEADROOM = 2'h1;
   localparam logic [1:0] CS_SUP_OVERVOLT = 2'h2;
   localparam logic [1:0] CS_SUP_VALID = 2'h3;

   // Battery temperature zones
   localparam logic [2:0] CS_TZ_NOMINAL = 3'h0;
   localparam logic [2:0] CS_TZ_COLD = 3'h1;
   localparam logic [2:0] CS_TZ_COOL = 3'h2;
   localparam logic [2:0] CS_TZ_WARM = 3'h3;
   localparam logic [2:0] CS_TZ_HOT = 3'h4;

   // Safety timer states
   localparam logic [1:0] CS_TMR_NO_EFFECT = 2'h0;

   // Die threshold decode: base and step in degrees C
   localparam logic [7:0] CS_THM_BASE_C = 8'h50;
   localparam logic [7:0] CS_THM_STEP_C = 8'h05;

   // Conditions arriving from the analog side
   typedef struct packed {
      logic battery_attach;
      logic [2:0] battery_condition_code;
      logic [1:0] input_supply_state;
      logic [2:0] battery_temp_zone;
      logic [1:0] safety_timer_state;
      logic input_current_limit_hit;
      logic [7:0] die_temp_c;
   } cs_cond_t;

   localparam cs_cond_t CS_COND_RST = '{
      battery_attach: 1'b0,
      battery_condition_code: CS_BAT_IN_RESET,
      input_supply_state: CS_SUP_UNDERVOLT,
      battery_temp_zone: CS_TZ_NOMINAL,
      safety_timer_state: CS_TMR_NO_EFFECT,
      input_current_limit_hit: 1'b0,
      die_temp_c: 8'h00
   };

   // Derived summary flags
   typedef struct packed {
      logic battery_attach_flag;
      logic battery_valid;
      logic input_power_good;
      logic charger_running_flag;
      logic thermal_foldback_flag;
   } cs_flags_t;

   // Host register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cs_req_t;

endpackage

`default_nettype wire

/* logic/cs_sync.sv */
/*
 Two flip-flop synchroniser for a group of asynchronous levels.
 Assumes the levels are quasi-static relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cs_sync
   import cs_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   // Clock, reset, enable
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   // First stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end
      else if (ce)
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule

`default_nettype wire

/* logic/cs_decode.sv */
/*
 Decoders for the thermistor beta select and die threshold select.
 Assumes select codes come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module cs_decode
   import cs_pkg::*;
(
   // Selects
   input wire logic [2:0] thermistor_beta_sel,
   input wire logic [2:0] die_heat_threshold_sel,
   // Decoded values
   output logic [12:0] beta_value_k,
   output logic [7:0] threshold_c
);

   // Beta table, rising with the code
   always_comb
   begin
      case (thermistor_beta_sel)
         3'h0: beta_value_k = 13'd3434;
         3'h1: beta_value_k = 13'd3610;
         3'h2: beta_value_k = 13'd3934;
         3'h3: beta_value_k = 13'd3950;
         3'h4: beta_value_k = 13'd4100;
         3'h5: beta_value_k = 13'd4311;
         3'h6: beta_value_k = 13'd4543;
         3'h7: beta_value_k = 13'd4750;
         default: beta_value_k = 13'd3434;
      endcase
   end

   // Base plus step per code
   logic [7:0] step_prod;
   assign step_prod = 8'(CS_THM_STEP_C * {5'h00, die_heat_threshold_sel});
   assign threshold_c = 8'(CS_THM_BASE_C + step_prod);

endmodule

`default_nettype wire

/* test/cs_status_assertions.sv */
/*
 Port checker for the charger status bank.
 Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module cs_status_assertions
   import cs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // Host port
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // Conditions
   input wire logic battery_attach,
   input wire logic [2:0] battery_condition_code,
   input wire logic [1:0] input_supply_state,
   input wire logic [2:0] battery_temp_zone,
   input wire logic [1:0] safety_timer_state,
   input wire logic input_current_limit_hit,
   input wire logic [7:0] die_temp_c,
   // Flags and settings
   input wire logic [7:0] die_heat_threshold_c,
   input wire logic charger_running_flag,
   input wire logic thermal_foldback_flag,
   input wire logic input_power_good,
   input wire logic status_readable
);
   logic [1:0] up_ff;
   logic up_ok;
   // Counts edges until synchronisers hold post-reset samples
   always_ff @(posedge clock)
   begin
      if (!rst_n || !ce)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   end
   assign up_ok = (up_ff == 2'h3);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_pgood_follows: assert property (
      up_ok |-> input_power_good == ($past(input_supply_state, 3) == 2'h3))
      else $error("power good flag wrong");
   a_run_follows: assert property (
      up_ok |-> charger_running_flag == !($past(battery_temp_zone, 3) inside
      {3'h1, 3'h4} || $past(safety_timer_state, 3) != 2'h0))
      else $error("running flag wrong");
   a_readable_follows: assert property (
      up_ok |-> status_readable == !$past(input_current_limit_hit, 3))
      else $error("readable flag wrong");
   a_fold_follows: assert property (
      up_ok && $past(die_heat_threshold_c, 3) == die_heat_threshold_c |->
      thermal_foldback_flag == ($past(die_temp_c, 3) > die_heat_threshold_c))
      else $error("foldback flag wrong");
   a_summary_read: assert property (
      up_ok && ce && reg_rd && reg_addr == 8'h18 |=>
      reg_rdata[7] == $past(battery_attach, 3) && reg_rdata[3:0] == 4'h0 &&
      reg_rdata[6] == !($past(battery_condition_code, 3) inside {3'h0, 3'h7}))
      else $error("summary read wrong");
   a_input_read: assert property (
      up_ok && ce && reg_rd && reg_addr == 8'h19 |=>
      reg_rdata[5] == 1'b0 &&
      reg_rdata[7:6] == $past(input_supply_state, 3) && reg_rdata[3:0] == 4'h0)
      else $error("input status read wrong");
   a_read_answer: assert property (
      ce && reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_thresh_decode: assert property (
      ce && reg_wr && reg_addr == 8'h17 ##1 (ce && !reg_wr)[*3] |->
      die_heat_threshold_c == 8'h50 + 8'h05 * $past(reg_wdata[2:0], 3))
      else $error("threshold decode wrong");
endmodule
bind cs_status_regs cs_status_assertions u_chk (.clock(clock), .rst_n(rst_n),
   .ce(ce), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .battery_attach(battery_attach),
   .battery_condition_code(battery_condition_code),
   .input_supply_state(input_supply_state),
   .battery_temp_zone(battery_temp_zone),
   .safety_timer_state(safety_timer_state),
   .input_current_limit_hit(input_current_limit_hit),
   .die_temp_c(die_temp_c), .die_heat_threshold_c(die_heat_threshold_c),
   .charger_running_flag(charger_running_flag),
   .thermal_foldback_flag(thermal_foldback_flag),
   .input_power_good(input_power_good), .status_readable(status_readable));
`default_nettype wire

/* test/cs_host_model.sv */
/*
 Host model issuing single-cycle register reads and writes.
 Assumes one request per task call, driven 1 ns after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cs_host_model
   import cs_pkg::*;
(
   // Clock
   input wire logic clock,
   // Requests
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // Answers
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic status_readable
);
   initial
   begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'hff;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic ok);
      @(posedge clock);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      // Reading kept only while current limit is clear
      ok = reg_rvalid && status_readable;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
/*
 Self-checking bench for the charger status bank.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import cs_pkg::*;
;
   logic clock, rst_n, ce, reg_rd, reg_wr, reg_rvalid, status_readable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, die, thr_c, exp_thr, rdata, s;
   logic attach, limit, run_f, fold_f, pgood_f, ok;
   logic [2:0] code, zone, bsel;
   logic [1:0] supply, timer;
   logic [12:0] beta;
   logic [12:0] beta_tab [8] = '{13'hd6a, 13'he1a, 13'hf5e, 13'hf6e,
      13'h1004, 13'h10d7, 13'h11bf, 13'h128e};
   integer fails = 0, samples_checked = 0, seed, cycles = 0;
   cs_host_model host (.clock(clock), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .status_readable(status_readable));
   cs_status_regs uut (.clock(clock), .rst_n(rst_n), .ce(ce),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .battery_attach(attach), .battery_condition_code(code),
      .input_supply_state(supply), .battery_temp_zone(zone),
      .safety_timer_state(timer), .input_current_limit_hit(limit),
      .die_temp_c(die), .thermistor_beta_value(beta),
      .die_heat_threshold_c(thr_c), .charger_running_flag(run_f),
      .thermal_foldback_flag(fold_f), .input_power_good(pgood_f),
      .status_readable(status_readable));
   function automatic logic [7:0] exp_sum();
      exp_sum = {attach, !(code inside {3'h0, 3'h7}), supply == 2'h3,
         !(zone inside {3'h1, 3'h4} || timer != 2'h0), 4'h0};
   endfunction
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         report_and_stop();
      end
   end
   initial
   begin
      seed = 91075;
      rst_n = 1'b0;
      ce = 1'b1;
      {attach, limit, zone, timer, supply, die} = '0;
      code = 3'h7;
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check(beta, 13'he1a);
      check(thr_c, 8'h64);
      host.rd(8'h18, rdata, ok);
      check(rdata, 8'h10);
      host.rd(8'h19, rdata, ok);
      check(rdata, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         host.wr(8'h18, 8'($random(seed)));
         host.wr(8'h19, 8'($random(seed)));
         bsel = 3'($random(seed));
         host.wr(8'h17, {bsel, 2'h0, i[2:0]});
         exp_thr = 8'h50 + 8'h05 * i[2:0];
         attach = 1'($random(seed));
         code = i[2:0] + i[5:3];
         supply = 2'($random(seed));
         zone = 3'(i % 5);
         timer = i[0] ? 2'h0 : 2'($random(seed));
         limit = ($random(seed) & 3) == 0;
         die = exp_thr + 8'(i % 3) - 8'h01;
         repeat (4) @(posedge clock);
         #1;
         s = exp_sum();
         check(beta, beta_tab[bsel]);
         check(thr_c, exp_thr);
         check(pgood_f, supply == 2'h3);
         check(run_f, s[4]);
         check(fold_f, die > exp_thr);
         check(status_readable, !limit);
         host.rd(8'h18, rdata, ok);
         check(ok, !limit);
         if (ok)
            check(rdata, s);
         host.rd(8'h19, rdata, ok);
         if (ok)
            check(rdata, {supply, 1'b0, die > exp_thr, 4'h0});
      end
      // Clock enable low freezes the flags
      s = {6'h00, pgood_f, status_readable};
      ce = 1'b0;
      supply = ~supply;
      limit = !limit;
      repeat (4) @(posedge clock);
      #1;
      check({pgood_f, status_readable}, s[1:0]);
      ce = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check(pgood_f, supply == 2'h3);
      check(status_readable, !limit);
      // Mid-run reset restores the defaults
      rst_n = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check({run_f, fold_f, pgood_f, status_readable}, 4'h9);
      check(beta, 13'he1a);
      check(thr_c, 8'h64);
      rst_n = 1'b1;
      host.rd(8'h18, rdata, ok);
      check(ok, 1'b1);
      check(rdata, 8'h10);
      host.rd(8'h20, rdata, ok);
      check(rdata, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
